// *** irf_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module irf_core_model (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_slow,
	input wire logic i_push_valid,
	input wire logic [1:0] i_push_sel,
	input wire logic i_pop_valid,
	input wire logic [1:0] i_pop_sel,
	input wire logic i_vector_load,
	output logic o_instr_done,
	output logic [7:0] o_entries,
	output logic o_seq_err
);
	logic [2:0] gap;
	logic [1:0] push_exp;
	logic [1:0] pop_exp;

	// A slow core ends an instruction only every sixth cycle, so entry latency varies.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gap <= 3'h0;
			o_instr_done <= 1'b0;
			o_entries <= 8'h00;
			o_seq_err <= 1'b0;
			push_exp <= 2'h0;
			pop_exp <= 2'h0;
		end else begin
			gap <= (gap == 3'h0) ? (i_slow ? 3'h5 : 3'h0) : gap - 3'h1;
			o_instr_done <= (gap == 3'h0);
			if (i_push_valid) begin
				push_exp <= push_exp + 2'h1;
				if (i_push_sel !== push_exp) o_seq_err <= 1'b1;
			end
			if (i_pop_valid) begin
				pop_exp <= pop_exp + 2'h1;
				if (i_pop_sel !== pop_exp) o_seq_err <= 1'b1;
			end
			if (i_vector_load) begin
				o_entries <= o_entries + 8'h01;
				if (push_exp !== 2'h0) o_seq_err <= 1'b1;
			end
		end
	end
endmodule // irf_core_model
`default_nettype wire

// *** irf_irq_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module irf_irq_ctrl #(
	parameter int unsigned N_PERIPH = 6,
	parameter int unsigned N_PINS_A = 8,
	parameter int unsigned N_PINS_B = 8,
	parameter logic [31:0] HALT_WAKE_MASK = 32'h0000_003c
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [irf_pkg::AVS_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [1:0] i_reset_cause,
	input wire logic [N_PINS_A-1:0] i_ext_irq_line_a,
	input wire logic [N_PINS_A-1:0] i_line_a_pin_en,
	input wire logic [N_PINS_B-1:0] i_ext_irq_line_b,
	input wire logic [N_PINS_B-1:0] i_line_b_pin_en,
	input wire logic [N_PERIPH-1:0] i_periph_event,
	input wire logic i_safe_osc_switch,
	input wire logic i_osc_recovered,
	input wire logic i_instr_done,
	input wire logic i_trap,
	input wire logic i_return_from_handler,
	input wire logic i_mask_set,
	input wire logic i_mask_clr,
	input wire logic i_wait_enter,
	input wire logic i_halt_enter,
	output logic o_push_valid,
	output logic [1:0] o_push_sel,
	output logic o_pop_valid,
	output logic [1:0] o_pop_sel,
	output logic o_vector_load,
	output logic [15:0] o_vector,
	output logic o_global_mask,
	output logic o_wake
);
	import irf_pkg::*;

	localparam int unsigned NSRC = N_PERIPH + SRC_PERIPH;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (N_PERIPH < 1 || N_PERIPH > 16) begin : g_bad_periph
		$error("N_PERIPH must be 1 to 16");
	end
	if (N_PINS_A < 1 || N_PINS_B < 1) begin : g_bad_pins
		$error("each external line needs at least one pin");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		irf_state_t state;
		logic [1:0] step;
		logic boot;
		logic [7:0] misc;
		logic lvd_flag;
		logic wdg_flag;
		logic guard_ie;
		logic safe_flag;
		logic [N_PINS_A-1:0] a_sync1;
		logic [N_PINS_A-1:0] a_sync2;
		logic [N_PINS_B-1:0] b_sync1;
		logic [N_PINS_B-1:0] b_sync2;
		logic a_prev;
		logic b_prev;
		logic a_latch;
		logic b_latch;
		logic [N_PERIPH-1:0] per_flag;
		logic [N_PERIPH-1:0] per_en;
		logic [N_PERIPH-1:0] per_armed;
		logic mask;
		logic sleep_wait;
		logic sleep_halt;
		logic svc_trap;
		logic [4:0] svc_idx;
		logic [15:0] vector;
		logic vector_load;
		logic push_valid;
		logic pop_valid;
		logic wake;
		logic waitreq;
		logic [31:0] rdata;
	} irf_regs_t;

	irf_regs_t q_reg;
	irf_regs_t q_next;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic edge_hit(input logic [1:0] sens, input logic rise, input logic fall);
		case (sens)
			SENS_RISE: edge_hit = rise;
			SENS_FALL: edge_hit = fall;
			SENS_BOTH: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [4:0] top_src(input logic [NSRC-1:0] p);
		top_src = 5'h00;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (p[i]) begin
				top_src = 5'(i);
			end
		end
	endfunction

	function automatic logic [15:0] vec_of(input logic [4:0] idx);
		vec_of = 16'(VEC_SRC_BASE - 16'(idx) * VEC_STEP);
	endfunction

	// ----------------------------------------------------------------
	// Request detection
	// ----------------------------------------------------------------
	logic a_comb;
	logic b_comb;
	logic [1:0] a_sens;
	logic [1:0] b_sens;
	logic a_evt;
	logic b_evt;
	logic [NSRC-1:0] pend;
	logic [NSRC-1:0] halt_cap;
	logic [4:0] sel_idx;

	// Pins not enabled count as high, so they never hold the line low.
	assign a_comb = &(q_reg.a_sync2 | ~i_line_a_pin_en);
	assign b_comb = &(q_reg.b_sync2 | ~i_line_b_pin_en);
	assign a_sens = {q_reg.misc[MISC_A_HI], q_reg.misc[MISC_A_LO]};
	assign b_sens = {q_reg.misc[MISC_B_HI], q_reg.misc[MISC_B_LO]};
	assign a_evt = edge_hit(a_sens, a_comb & ~q_reg.a_prev, ~a_comb & q_reg.a_prev);
	assign b_evt = edge_hit(b_sens, b_comb & ~q_reg.b_prev, ~b_comb & q_reg.b_prev);

	// Level mode requests follow the line; edge modes use the latch.
	assign pend[SRC_LINE_A] = (a_sens == SENS_FALL_LOW) ? ~a_comb : q_reg.a_latch;
	assign pend[SRC_LINE_B] = (b_sens == SENS_FALL_LOW) ? ~b_comb : q_reg.b_latch;
	assign pend[SRC_GUARD] = q_reg.safe_flag & q_reg.guard_ie;
	assign pend[NSRC-1:SRC_PERIPH] = q_reg.per_flag & q_reg.per_en;
	assign halt_cap = {HALT_WAKE_MASK[N_PERIPH-1:0], 3'h3};
	assign sel_idx = top_src(pend);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic req;
		logic done;
		logic take;
		logic [N_PERIPH-1:0] per_keep;
		req = i_avs_read | i_avs_write;
		done = req & ~q_reg.waitreq;
		take = 1'b0;
		per_keep = '1;
		q_next = q_reg;
		q_next.vector_load = 1'b0;
		q_next.wake = 1'b0;
		q_next.a_sync1 = i_ext_irq_line_a;
		q_next.a_sync2 = q_reg.a_sync1;
		q_next.b_sync1 = i_ext_irq_line_b;
		q_next.b_sync2 = q_reg.b_sync1;
		q_next.a_prev = a_comb;
		q_next.b_prev = b_comb;

		// Cause flags are caught at the first edge after reset release.
		if (q_reg.boot) begin
			q_next.boot = 1'b0;
			q_next.lvd_flag = i_reset_cause[CAUSE_LVD];
			q_next.wdg_flag = i_reset_cause[CAUSE_WDG] & ~i_reset_cause[CAUSE_LVD];
		end

		// Bus slave: one wait cycle, data and effects at the acknowledging edge.
		q_next.waitreq = ~(req & q_reg.waitreq);
		if (req && q_reg.waitreq) begin
			case (i_avs_address)
				ADDR_MISC: q_next.rdata = {24'h0, q_reg.misc};
				ADDR_CLOCK_RESET_STATUS: q_next.rdata = {27'h0, q_reg.lvd_flag, 1'b0, q_reg.guard_ie,
					q_reg.safe_flag, q_reg.wdg_flag};
				ADDR_PFLAG: q_next.rdata = 32'(q_reg.per_flag);
				ADDR_PEN: q_next.rdata = 32'(q_reg.per_en);
				ADDR_CORE: q_next.rdata = {29'h0, q_reg.sleep_halt, q_reg.sleep_wait, q_reg.mask};
				default: q_next.rdata = 32'h0;
			endcase
		end
		if (done) begin
			case (i_avs_address)
				ADDR_MISC: begin
					if (i_avs_write) begin
						q_next.misc = i_avs_writedata[7:0];
					end
				end
				ADDR_CLOCK_RESET_STATUS: begin
					if (i_avs_write) begin
						q_next.guard_ie = i_avs_writedata[CLOCK_RESET_STATUS_IE];
						q_next.lvd_flag = q_next.lvd_flag & i_avs_writedata[CLOCK_RESET_STATUS_LVD];
						q_next.wdg_flag = q_next.wdg_flag & i_avs_writedata[CLOCK_RESET_STATUS_WDG];
					end else if (i_osc_recovered) begin
						q_next.safe_flag = 1'b0;
					end
				end
				ADDR_PFLAG: begin
					q_next.per_armed = q_reg.per_flag;
					if (i_avs_write) begin
						per_keep = i_avs_writedata[N_PERIPH-1:0];
					end
				end
				ADDR_PEN: begin
					if (i_avs_write) begin
						q_next.per_en = i_avs_writedata[N_PERIPH-1:0];
					end
				end
				ADDR_PASSOC: begin
					per_keep = ~q_reg.per_armed;
					q_next.per_armed = '0;
				end
				default: begin
				end
			endcase
		end

		// Core sequencing.
		unique case (q_reg.state)
			ST_IDLE: begin
				if (i_return_from_handler) begin
					q_next.state = ST_POP;
					q_next.step = 2'h0;
					q_next.pop_valid = 1'b1;
				end else if (i_trap || (i_instr_done && !q_reg.mask && |pend)) begin
					take = 1'b1;
				end else if (i_wait_enter || i_halt_enter) begin
					// Entering low power opens the mask; a pending request wakes at once whatever the mask, in halt only if it is in halt_cap.
					q_next.state = ST_SLEEP;
					q_next.mask = 1'b0;
					q_next.sleep_wait = i_wait_enter;
					q_next.sleep_halt = ~i_wait_enter;
				end else if (i_mask_set) begin
					q_next.mask = 1'b1;
				end else if (i_mask_clr) begin
					q_next.mask = 1'b0;
				end
			end
			ST_SLEEP: begin
				if (q_reg.sleep_halt ? |(pend & halt_cap) : |pend) begin
					q_next.wake = 1'b1;
					q_next.sleep_wait = 1'b0;
					q_next.sleep_halt = 1'b0;
					take = 1'b1;
				end
			end
			ST_PUSH: begin
				if (q_reg.step == STACK_LAST) begin
					q_next.state = ST_VECT;
					q_next.push_valid = 1'b0;
				end else begin
					q_next.step = q_reg.step + 2'h1;
				end
			end
			ST_VECT: begin
				q_next.state = ST_IDLE;
				q_next.mask = 1'b1;
				q_next.vector_load = 1'b1;
				if (!q_reg.svc_trap && q_reg.svc_idx == 5'(SRC_LINE_A)) begin
					q_next.a_latch = 1'b0;
				end
				if (!q_reg.svc_trap && q_reg.svc_idx == 5'(SRC_LINE_B)) begin
					q_next.b_latch = 1'b0;
				end
			end
			ST_POP: begin
				if (q_reg.step == STACK_LAST) begin
					q_next.state = ST_IDLE;
					q_next.pop_valid = 1'b0;
					q_next.mask = 1'b0;
				end else begin
					q_next.step = q_reg.step + 2'h1;
				end
			end
		endcase

		// The serviced vector is frozen at acceptance so a level request that
		// drops during stacking cannot change the handler being entered.
		if (take) begin
			q_next.state = ST_PUSH;
			q_next.step = 2'h0;
			q_next.push_valid = 1'b1;
			q_next.svc_trap = i_trap && q_reg.state == ST_IDLE;
			q_next.svc_idx = sel_idx;
			q_next.vector = q_next.svc_trap ? VEC_TRAP : vec_of(sel_idx);
		end

		// Hardware sets come last so they win over any clear in the same cycle.
		q_next.per_flag = (q_reg.per_flag & per_keep) | i_periph_event;
		if (a_evt) begin
			q_next.a_latch = 1'b1;
		end
		if (b_evt) begin
			q_next.b_latch = 1'b1;
		end
		if (i_safe_osc_switch) begin
			q_next.safe_flag = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q_reg <= '0;
			q_reg.state <= ST_IDLE;
			q_reg.boot <= 1'b1;
			// Synchronisers start at the idle high pin level, so that neither a
			// level request nor an edge is seen while they fill after reset.
			q_reg.a_sync1 <= '1;
			q_reg.a_sync2 <= '1;
			q_reg.b_sync1 <= '1;
			q_reg.b_sync2 <= '1;
			q_reg.a_prev <= 1'b1;
			q_reg.b_prev <= 1'b1;
			q_reg.misc <= MISC_RESET;
			q_reg.vector <= VEC_RESET;
			q_reg.waitreq <= 1'b1;
		end else begin
			q_reg <= q_next;
		end
	end

	assign o_avs_readdata = q_reg.rdata;
	assign o_avs_waitrequest = q_reg.waitreq;
	assign o_push_valid = q_reg.push_valid;
	assign o_push_sel = q_reg.step;
	assign o_pop_valid = q_reg.pop_valid;
	assign o_pop_sel = q_reg.step;
	assign o_vector_load = q_reg.vector_load;
	assign o_vector = q_reg.vector;
	assign o_global_mask = q_reg.mask;
	assign o_wake = q_reg.wake;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_SAFE_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_safe_osc_switch |=> q_reg.safe_flag)
		else $error("safe oscillator flag not set after switch");
	AST_GUARD_GATED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(q_reg.state == ST_IDLE && !q_reg.guard_ie && q_reg.safe_flag && !q_reg.mask
		&& i_instr_done && !i_trap && !i_return_from_handler && !pend[SRC_LINE_A]
		&& !pend[SRC_LINE_B] && !(|(q_reg.per_flag & q_reg.per_en))) |=> !o_push_valid)
		else $error("clock guard serviced while disabled");
	AST_PUSH_FOUR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$rose(o_push_valid) |-> o_push_valid[*4] ##1 !o_push_valid)
		else $error("stacking did not last four cycles");
	AST_MASK_AFTER_STACK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$fell(o_push_valid) |=> o_vector_load && o_global_mask)
		else $error("vector load or mask missing after stacking");
	AST_RETURN_UNMASKS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$fell(o_pop_valid) |-> !o_global_mask)
		else $error("mask still set after unstacking");
	AST_TRAP_VECTOR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(q_reg.state == ST_IDLE && i_trap && !i_return_from_handler)
		|=> ##5 o_vector_load && o_vector == VEC_TRAP)
		else $error("trap did not load its vector");
	AST_NO_TAKE_MASKED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(q_reg.state == ST_IDLE && q_reg.mask && !i_trap) |=> !$rose(o_push_valid))
		else $error("maskable request taken while masked");
	AST_RESV_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_avs_read && !o_avs_waitrequest && i_avs_address == ADDR_CLOCK_RESET_STATUS)
		|-> o_avs_readdata[7:5] == 3'h0 && !o_avs_readdata[3])
		else $error("reserved status bits read nonzero");
	AST_WDG_WRITE_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_avs_write && !o_avs_waitrequest && i_avs_address == ADDR_CLOCK_RESET_STATUS
		&& !i_avs_writedata[CLOCK_RESET_STATUS_WDG] && !q_reg.boot) |=> !q_reg.wdg_flag)
		else $error("watchdog flag survived zero write");

endmodule // irf_irq_ctrl
`default_nettype wire

// *** irf_pkg.sv ***
package irf_pkg;

	// ----------------------------------------------------------------
	// Register map (printed offsets are indices, byte address is 4x)
	// ----------------------------------------------------------------
	localparam int unsigned AVS_AW = 8;
	localparam int unsigned IDX_MISC = 32'h20;
	localparam int unsigned IDX_CLOCK_RESET_STATUS = 32'h25;
	localparam logic [AVS_AW-1:0] ADDR_MISC = 8'(IDX_MISC * 4);
	localparam logic [AVS_AW-1:0] ADDR_CLOCK_RESET_STATUS = 8'(IDX_CLOCK_RESET_STATUS * 4);
	localparam logic [AVS_AW-1:0] ADDR_PFLAG = 8'ha0;
	localparam logic [AVS_AW-1:0] ADDR_PEN = 8'ha4;
	localparam logic [AVS_AW-1:0] ADDR_PASSOC = 8'ha8;
	localparam logic [AVS_AW-1:0] ADDR_CORE = 8'hac;

	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam int unsigned CLOCK_RESET_STATUS_WDG = 0;
	localparam int unsigned CLOCK_RESET_STATUS_SAFE = 1;
	localparam int unsigned CLOCK_RESET_STATUS_IE = 2;
	localparam int unsigned CLOCK_RESET_STATUS_LVD = 4;
	localparam int unsigned MISC_A_LO = 3;
	localparam int unsigned MISC_A_HI = 4;
	localparam int unsigned MISC_B_LO = 6;
	localparam int unsigned MISC_B_HI = 7;
	localparam int unsigned CAUSE_WDG = 0;
	localparam int unsigned CAUSE_LVD = 1;

	// ----------------------------------------------------------------
	// Vectors and sources
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_TRAP = 16'hfffc;
	localparam logic [15:0] VEC_SRC_BASE = 16'hfffa;
	localparam logic [15:0] VEC_STEP = 16'h0002;
	localparam int unsigned SRC_LINE_A = 0;
	localparam int unsigned SRC_LINE_B = 1;
	localparam int unsigned SRC_GUARD = 2;
	localparam int unsigned SRC_PERIPH = 3;
	localparam logic [1:0] STACK_LAST = 2'h3;

	typedef enum logic [1:0] {
		SENS_FALL_LOW = 2'h0,
		SENS_RISE = 2'h1,
		SENS_FALL = 2'h2,
		SENS_BOTH = 2'h3
	} irf_sens_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_PUSH = 5'h02,
		ST_VECT = 5'h04,
		ST_POP = 5'h08,
		ST_SLEEP = 5'h10
	} irf_state_t;

endpackage

// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import irf_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [1:0] cause = 2'h0;
	logic [1:0] la = 2'h3;
	logic [1:0] lb = 2'h3;
	logic [1:0] ena = 2'h3;
	logic [1:0] enb = 2'h3;
	logic [5:0] pev = 6'h00;
	logic [6:0] ctl = 7'h00;
	logic rec = 1'b0;
	logic slow = 1'b0;
	wire logic [31:0] rdata;
	wire logic wreq, push_v, pop_v, vl, gmask, wake, idone, serr;
	wire logic [1:0] push_s, pop_s;
	wire logic [15:0] vec;
	wire logic [7:0] ents;
	int miscompares = 0;
	int n_tests = 0;
	int nwake = 0;
	int k, w;
	logic [31:0] r;

	always #10 clk = ~clk;
	always @(posedge clk) if (wake === 1'b1) nwake++;

	irf_irq_ctrl #(.N_PINS_A(2), .N_PINS_B(2)) u_irf_irq_ctrl (.i_clk(clk), .i_sys_rst(rst),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_reset_cause(cause),
		.i_ext_irq_line_a(la), .i_line_a_pin_en(ena), .i_ext_irq_line_b(lb),
		.i_line_b_pin_en(enb), .i_periph_event(pev), .i_safe_osc_switch(ctl[0]),
		.i_osc_recovered(rec), .i_instr_done(idone), .i_trap(ctl[1]),
		.i_return_from_handler(ctl[2]), .i_mask_set(ctl[3]), .i_mask_clr(ctl[4]),
		.i_wait_enter(ctl[5]), .i_halt_enter(ctl[6]), .o_push_valid(push_v),
		.o_push_sel(push_s), .o_pop_valid(pop_v), .o_pop_sel(pop_s), .o_vector_load(vl),
		.o_vector(vec), .o_global_mask(gmask), .o_wake(wake));

	irf_core_model u_irf_core_model (.i_clk(clk), .i_sys_rst(rst), .i_slow(slow),
		.i_push_valid(push_v), .i_push_sel(push_s), .i_pop_valid(pop_v), .i_pop_sel(pop_s),
		.i_vector_load(vl), .o_instr_done(idone), .o_entries(ents), .o_seq_err(serr));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Source index: line A 0, line B 1, clock guard 2, peripheral k at 3 + k.
	function automatic logic [15:0] vec_exp(input int src);
		return 16'(32'hfffa - 32'(2 * src));
	endfunction

	// Waits without a fixed count; the watchdog ends a hung slave.
	task bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= we;
		rd <= !we;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task wreg(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, r);
	endtask

	task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, r);
		chk(nm, r, exp);
	endtask

	task pulse(input int b);
		@(posedge clk);
		ctl[b] <= 1'b1;
		@(posedge clk);
		ctl[b] <= 1'b0;
	endtask

	task pe(input int b);
		@(posedge clk);
		pev <= 6'(1 << b);
		@(posedge clk);
		pev <= 6'h00;
	endtask

	task lines(input logic [1:0] a, input logic [1:0] b);
		@(posedge clk);
		la <= a;
		lb <= b;
		repeat (4) @(posedge clk);
	endtask

	task entry(input logic [15:0] v);
		int n;
		n = 0;
		while (vl !== 1'b1 && n < 80) begin
			@(posedge clk);
			n++;
		end
		chk("vector", {16'h0, vec}, {16'h0, v});
		chk("mask on entry", {31'h0, gmask}, 32'h1);
		@(posedge clk);
	endtask

	task quiet();
		logic [7:0] c;
		c = ents;
		repeat (30) @(posedge clk);
		chk("entries", {24'h0, ents}, {24'h0, c});
	endtask

	task ret();
		int n;
		pulse(2);
		n = 0;
		while (pop_v !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		while (pop_v !== 1'b0 && n < 30) begin
			@(posedge clk);
			n++;
		end
		chk("mask after return", {31'h0, gmask}, 32'h0);
		chk("stack order", {31'h0, serr}, 32'h0);
	endtask

	task do_reset(input logic [1:0] c);
		@(posedge clk);
		rst <= 1'b1;
		cause <= c;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h08a24f4b));
		slow = 1'($urandom);
		for (int c = 0; c < 4; c++) begin
			do_reset(c[1:0]);
			rchk("status", ADDR_CLOCK_RESET_STATUS, {27'h0, c[1], 3'h0, c[0] & !c[1]});
			rchk("misc", ADDR_MISC, 32'h0);
		end
		$display("test reset flags done");
		wreg(ADDR_CLOCK_RESET_STATUS, 32'hff);
		rchk("status", ADDR_CLOCK_RESET_STATUS, 32'h14);
		wreg(ADDR_CLOCK_RESET_STATUS, 32'h00);
		rchk("status", ADDR_CLOCK_RESET_STATUS, 32'h00);
		repeat (4) begin
			k = $urandom;
			wreg(ADDR_MISC, {24'h0, k[7:0]});
			rchk("misc", ADDR_MISC, {24'h0, k[7:0]});
		end
		wreg(8'h04, 32'hff);
		rchk("unmapped", 8'h04, 32'h0);
		pulse(3);
		rchk("core", ADDR_CORE, 32'h1);
		pulse(4);
		rchk("core", ADDR_CORE, 32'h0);
		$display("test registers done");
		pulse(0);
		rchk("status", ADDR_CLOCK_RESET_STATUS, 32'h02);
		quiet();
		rchk("status", ADDR_CLOCK_RESET_STATUS, 32'h02);
		wreg(ADDR_CLOCK_RESET_STATUS, 32'h04);
		entry(16'hfff6);
		@(posedge clk);
		rec <= 1'b1;
		rchk("status", ADDR_CLOCK_RESET_STATUS, 32'h06);
		rchk("status", ADDR_CLOCK_RESET_STATUS, 32'h04);
		ret();
		quiet();
		wreg(ADDR_CLOCK_RESET_STATUS, 32'h00);
		$display("test clock guard done");
		for (int c = 0; c < 4; c++) begin
			wreg(ADDR_MISC, {27'h0, c[1], c[0], 3'h0});
			lines(2'h1, 2'h3);
			if (c != 1) begin
				entry(VEC_SRC_BASE);
				lines(2'h3, 2'h3);
				ret();
			end else begin
				quiet();
				lines(2'h3, 2'h3);
			end
			if (c[0]) begin
				entry(VEC_SRC_BASE);
				ret();
			end
			quiet();
		end
		wreg(ADDR_MISC, 32'h08);
		lines(2'h0, 2'h3);
		lines(2'h1, 2'h3);
		quiet();
		lines(2'h3, 2'h3);
		entry(16'hfffa);
		ret();
		$display("test line sensitivity done");
		wreg(ADDR_MISC, 32'h88);
		wreg(ADDR_PEN, 32'h01);
		pulse(3);
		pe(0);
		lines(2'h1, 2'h2);
		lines(2'h3, 2'h2);
		quiet();
		pulse(1);
		entry(VEC_TRAP);
		ret();
		entry(16'hfffa);
		ret();
		entry(16'hfff8);
		ret();
		entry(16'hfff4);
		wreg(ADDR_PFLAG, 32'h0);
		ret();
		quiet();
		lines(2'h3, 2'h3);
		$display("test priority done");
		k = $urandom_range(5, 0);
		wreg(ADDR_PEN, 32'h0);
		pe(k);
		quiet();
		rchk("flags", ADDR_PFLAG, 32'(1 << k));
		wreg(ADDR_PASSOC, 32'h0);
		rchk("flags", ADDR_PFLAG, 32'h0);
		wreg(ADDR_PEN, 32'(1 << k));
		quiet();
		pulse(5);
		w = nwake;
		pe(k);
		entry(vec_exp(3 + k));
		chk("wakes", 32'(nwake - w), 32'h1);
		wreg(ADDR_PFLAG, 32'h0);
		ret();
		$display("test peripheral and wait done");
		wreg(ADDR_PEN, 32'h01);
		pulse(6);
		w = nwake;
		pe(0);
		quiet();
		chk("wakes", 32'(nwake - w), 32'h0);
		lines(2'h1, 2'h3);
		lines(2'h3, 2'h3);
		entry(16'hfffa);
		chk("wakes", 32'(nwake - w), 32'h1);
		ret();
		entry(16'hfff4);
		wreg(ADDR_PFLAG, 32'h0);
		ret();
		$display("test halt done");
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
